/* design/ifd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module ifd_decoder
  import ifd_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        start,
  input  wire ifd_kind_e   kind,
  input  wire logic [7:0]  opcode,
  input  wire logic        group_op,
  input  wire logic [15:0] next_ip,
  input  wire logic        byte_valid,
  input  wire logic [7:0]  byte_in,
  input  wire logic        bus_configuration_strap,
  output logic             byte_take,
  output logic             busy,
  output logic             done,
  output logic             word_op,
  output logic [1:0]       mode_field,
  output logic [2:0]       reg_field,
  output logic [2:0]       rm_field,
  output logic [2:0]       op_select,
  output logic [1:0]       segment_selector_field,
  output logic             ea_needed,
  output logic [15:0]      displacement,
  output logic [15:0]      operand,
  output logic [15:0]      target_ip,
  output logic [15:0]      target_cs,
  output logic [5:0]       escape_opcode,
  output logic             internal_bus_ctrl
);
  ifd_state_e  state;
  ifd_state_e  next_state;
  ifd_kind_e   cur_kind;
  logic [15:0] base_ip;
  logic        sx;
  logic [7:0]  lo_hold;
  logic        take;

  function automatic logic [15:0] widen(input logic [7:0] b);
    widen = {{BYTE_W{b[BYTE_W-1]}}, b};
  endfunction : widen

  function automatic logic [15:0] join_bytes(input logic [7:0] lo,
                                             input logic [7:0] hi);
    join_bytes = {hi, lo};
  endfunction : join_bytes

  function automatic ifd_state_e after_disp(input ifd_kind_e k);
    after_disp = (k == IFD_K_MODRM_I) ? IFD_S_I_LO : IFD_S_DONE;
  endfunction : after_disp

  assign take = byte_valid && (state != IFD_S_IDLE) && (state != IFD_S_DONE);

  // Minimum mode drives bus control itself; maximum mode leaves it outside
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      internal_bus_ctrl <= 1'b1;
    end else begin
      internal_bus_ctrl <= bus_configuration_strap;
    end
  end

  always_comb begin
    next_state = state;
    unique case (state)
      IFD_S_IDLE: begin
        if (start) begin
          unique case (kind)
            IFD_K_MODRM, IFD_K_MODRM_I, IFD_K_ESC: next_state = IFD_S_MODRM;
            IFD_K_IMM, IFD_K_REL8, IFD_K_REL16, IFD_K_FAR,
            IFD_K_DIRECT: next_state = IFD_S_I_LO;
            default: next_state = IFD_S_DONE;
          endcase
        end
      end
      IFD_S_MODRM: begin
        if (take) begin
          unique case (byte_in[7:MOD_LSB])
            MOD_NODISP: next_state = (byte_in[2:0] == RM_DIRECT)
                                     ? IFD_S_D_LO : after_disp(cur_kind);
            MOD_DISP8, MOD_DISP16: next_state = IFD_S_D_LO;
            MOD_REG: next_state = after_disp(cur_kind);
          endcase
        end
      end
      IFD_S_D_LO: begin
        if (take) begin
          next_state = (mode_field == MOD_DISP8) ? after_disp(cur_kind)
                                                 : IFD_S_D_HI;
        end
      end
      IFD_S_D_HI: if (take) next_state = after_disp(cur_kind);
      IFD_S_I_LO: begin
        if (take) begin
          // One byte only for byte immediates, sign-widened forms, short jumps; near, far and direct forms always take two
          if (cur_kind == IFD_K_REL8 ||
              (cur_kind != IFD_K_REL16 && cur_kind != IFD_K_FAR &&
               cur_kind != IFD_K_DIRECT && (!word_op || sx))) begin
            next_state = IFD_S_DONE;
          end else begin
            next_state = IFD_S_I_HI;
          end
        end
      end
      IFD_S_I_HI: begin
        if (take) begin
          next_state = (cur_kind == IFD_K_FAR) ? IFD_S_S_LO : IFD_S_DONE;
        end
      end
      IFD_S_S_LO: if (take) next_state = IFD_S_S_HI;
      IFD_S_S_HI: if (take) next_state = IFD_S_DONE;
      IFD_S_DONE: next_state = IFD_S_IDLE;
      default: next_state = IFD_S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state <= IFD_S_IDLE;
      busy <= 1'b0;
      done <= 1'b0;
      byte_take <= 1'b0;
    end else begin
      state <= next_state;
      busy <= (next_state != IFD_S_IDLE) && (next_state != IFD_S_DONE);
      done <= (next_state == IFD_S_DONE);
      byte_take <= take;
    end
  end

  // Opcode-level fields latched at start; escape low triplet from the operand byte
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cur_kind <= IFD_K_NONE;
      base_ip <= '0;
      sx <= 1'b0;
      word_op <= 1'b0;
      escape_opcode <= '0;
    end else if (state == IFD_S_IDLE && start) begin
      cur_kind <= kind;
      base_ip <= next_ip;
      word_op <= opcode[0];
      // Sign bit only meaningful for the immediate group forms
      sx <= (kind == IFD_K_MODRM_I) && opcode[1];
      escape_opcode[5:3] <= opcode[2:0];
    end else if (state == IFD_S_MODRM && take && cur_kind == IFD_K_ESC) begin
      escape_opcode[2:0] <= byte_in[5:3];
    end
  end

  // Operand-byte fields
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      mode_field <= MOD_REG;
      reg_field <= '0;
      rm_field <= '0;
      op_select <= '0;
      segment_selector_field <= SEG_DATA;
      ea_needed <= 1'b0;
    end else if (state == IFD_S_IDLE && start) begin
      // Forms without an operand byte never compute an address
      ea_needed <= 1'b0;
    end else if (state == IFD_S_MODRM && take) begin
      mode_field <= byte_in[7:MOD_LSB];
      reg_field <= byte_in[5:REG_LSB];
      rm_field <= byte_in[2:0];
      op_select <= group_op ? byte_in[5:REG_LSB] : '0;
      // Upper reg bit is don't-care for segment moves
      segment_selector_field <= byte_in[SEG_LSB+1:SEG_LSB];
      ea_needed <= (byte_in[7:MOD_LSB] != MOD_REG) &&
                   !(byte_in[7:MOD_LSB] == MOD_NODISP &&
                     byte_in[2:0] == RM_DIRECT);
    end
  end

  // Byte assembly
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      displacement <= '0;
      operand <= '0;
      target_ip <= '0;
      target_cs <= '0;
      lo_hold <= '0;
    end else if (state == IFD_S_IDLE && start) begin
      displacement <= '0;
      operand <= '0;
    end else if (take) begin
      unique case (state)
        IFD_S_D_LO: begin
          // Displacement is unsigned: high byte zero unless fetched
          displacement <= join_bytes(byte_in, 8'h00);
        end
        IFD_S_D_HI: displacement[15:8] <= byte_in;
        IFD_S_I_LO: begin
          lo_hold <= byte_in;
          if (cur_kind == IFD_K_REL8) begin
            target_ip <= base_ip + widen(byte_in);
          end else if (sx && word_op) begin
            operand <= widen(byte_in);
          end else begin
            operand <= join_bytes(byte_in, 8'h00);
          end
        end
        IFD_S_I_HI: begin
          unique case (cur_kind)
            IFD_K_REL16: target_ip <= base_ip +
                                      join_bytes(lo_hold, byte_in);
            IFD_K_FAR: target_ip <= join_bytes(lo_hold, byte_in);
            IFD_K_DIRECT: begin
              displacement <= join_bytes(lo_hold, byte_in);
              operand <= join_bytes(lo_hold, byte_in);
            end
            default: operand <= join_bytes(lo_hold, byte_in);
          endcase
        end
        IFD_S_S_LO: lo_hold <= byte_in;
        IFD_S_S_HI: target_cs <= join_bytes(lo_hold, byte_in);
        default: lo_hold <= lo_hold;
      endcase
    end
  end

  segment_code_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ($past(state) == IFD_S_MODRM && $past(take)) |->
      segment_selector_field == $past(byte_in[4:3]))
    else $error("segment selector not taken from operand byte");

  sign_widen_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ($past(state) == IFD_S_I_LO && $past(take) && $past(sx) &&
     $past(word_op) && $past(cur_kind) != IFD_K_REL8) |->
      operand[15:8] == {8{operand[7]}})
    else $error("sign widened immediate wrong");

  disp8_len_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == IFD_S_D_LO && take && mode_field == MOD_DISP8) |=>
      state != IFD_S_D_HI)
    else $error("one byte displacement fetched a high byte");

  // Done is registered on the taking edge, so it stands with the target
  short_rel_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == IFD_S_I_LO && take && cur_kind == IFD_K_REL8) |=>
      (target_ip == base_ip + {{BYTE_W{$past(byte_in[BYTE_W-1])}},
                               $past(byte_in)}) && done)
    else $error("short relative target wrong");

  far_order_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == IFD_S_I_HI && take && cur_kind == IFD_K_FAR) |=>
      state == IFD_S_S_LO)
    else $error("far segment bytes not after pointer");

  escape_join_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == IFD_S_MODRM && take && cur_kind == IFD_K_ESC) |=>
      escape_opcode[2:0] == $past(byte_in[5:3]))
    else $error("escape second triplet wrong");

  strap_follow_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    ##1 internal_bus_ctrl == $past(bus_configuration_strap))
    else $error("bus control does not follow strap");

  byte_len_a: assert property (
    @(posedge ref_clk) disable iff (srst)
    (state == IFD_S_I_LO && take && cur_kind == IFD_K_IMM && !word_op) |=>
      done)
    else $error("byte immediate fetched two bytes");
endmodule : ifd_decoder
`default_nettype wire

/* design/ifd_pkg.sv */
package ifd_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned TRIP_W = 3;
  localparam int unsigned MOD_LSB = 6;
  localparam int unsigned REG_LSB = 3;
  localparam int unsigned SEG_LSB = 3;
  localparam logic [1:0] MOD_NODISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;
  localparam logic [1:0] SEG_EXTRA = 2'h0;
  localparam logic [1:0] SEG_CODE = 2'h1;
  localparam logic [1:0] SEG_STACK = 2'h2;
  localparam logic [1:0] SEG_DATA = 2'h3;
  // Operand field kinds supplied by the opcode map
  typedef enum logic [3:0] {
    IFD_K_NONE    = 4'h0,
    IFD_K_MODRM   = 4'h1,
    IFD_K_MODRM_I = 4'h2,
    IFD_K_IMM     = 4'h3,
    IFD_K_REL8    = 4'h4,
    IFD_K_REL16   = 4'h5,
    IFD_K_FAR     = 4'h6,
    IFD_K_DIRECT  = 4'h7,
    IFD_K_ESC     = 4'h8
  } ifd_kind_e;
  typedef enum logic [3:0] {
    IFD_S_IDLE  = 4'h0,
    IFD_S_MODRM = 4'h1,
    IFD_S_D_LO  = 4'h3,
    IFD_S_D_HI  = 4'h2,
    IFD_S_I_LO  = 4'h6,
    IFD_S_I_HI  = 4'h7,
    IFD_S_S_LO  = 4'h5,
    IFD_S_S_HI  = 4'h4,
    IFD_S_DONE  = 4'hC
  } ifd_state_e;
endpackage : ifd_pkg

/* tb/test_ifd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module test_ifd_decoder
  import ifd_pkg::*;
;
  typedef struct packed {
    ifd_kind_e   kind;
    logic [7:0]  op;
    logic        grp;
    logic [15:0] ip;
    logic [2:0]  nb;
    logic [47:0] bytes;
    logic [15:0] a;
    logic [15:0] b;
    logic [1:0]  c;
  } ifd_row_s;

  logic        ref_clk = 1'h0;
  logic        srst = 1'h1;
  logic        start = 1'h0;
  logic        group_op = 1'h0;
  logic        byte_valid = 1'h0;
  logic        strap = 1'h1;
  ifd_kind_e   kind = IFD_K_NONE;
  logic [7:0]  opcode = 8'h00;
  logic [7:0]  byte_in = 8'h5A;
  logic [15:0] next_ip = 16'h0000;
  logic        byte_take, busy, done, word_op, ea_needed, internal_bus_ctrl;
  logic [1:0]  mode_field, segment_selector_field;
  logic [2:0]  reg_field, rm_field, op_select;
  logic [15:0] displacement, operand, target_ip, target_cs;
  logic [5:0]  escape_opcode;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          takes = 0;
  ifd_row_s    rows [21];

  ifd_decoder dut (
    .ref_clk, .srst, .start, .kind, .opcode, .group_op, .next_ip,
    .byte_valid, .byte_in, .bus_configuration_strap(strap), .byte_take,
    .busy, .done, .word_op, .mode_field, .reg_field, .rm_field, .op_select,
    .segment_selector_field, .ea_needed, .displacement, .operand,
    .target_ip, .target_cs, .escape_opcode, .internal_bus_ctrl
  );

  always #5 ref_clk = ~ref_clk;

  // Byte_take lags the consumption by a cycle, so counting it gives the
  // number of stream bytes each decode swallowed
  always @(posedge ref_clk) begin
    if (byte_take === 1'h1) takes <= takes + 1;
  end

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  task automatic wait_done();
    int k;
    k = 0;
    while (done !== 1'h1 && k < 8) begin
      @(negedge ref_clk);
      k++;
    end
    check("done", 16'(done), 16'h1);
    @(negedge ref_clk);
  endtask : wait_done

  task automatic launch(input ifd_row_s r);
    @(negedge ref_clk);
    takes = 0;
    start = 1'h1;
    kind = r.kind;
    opcode = r.op;
    group_op = r.grp;
    next_ip = r.ip;
    @(negedge ref_clk);
    start = 1'h0;
  endtask : launch

  task automatic run(input ifd_row_s r);
    launch(r);
    for (int k = 0; k < r.nb; k++) begin
      // A stall before the second byte, with garbage on the stream
      if (k == 1) begin
        byte_valid = 1'h0;
        byte_in = ~byte_in;
        @(negedge ref_clk);
      end
      byte_valid = 1'h1;
      byte_in = r.bytes[8*k +: 8];
      @(negedge ref_clk);
    end
    byte_valid = 1'h0;
    byte_in = ~byte_in;
    wait_done();
    check("byte count", 16'(takes), 16'(r.nb));
  endtask : run

  task automatic verify(input ifd_row_s r);
    case (r.kind)
      IFD_K_IMM: begin
        check("operand", operand, r.a);
        check("word_op", 16'(word_op), r.b);
      end
      IFD_K_MODRM_I: begin
        check("displacement", displacement, r.a);
        check("operand", operand, r.b);
      end
      IFD_K_REL8, IFD_K_REL16: check("target_ip", target_ip, r.a);
      IFD_K_FAR: begin
        check("target_ip", target_ip, r.a);
        check("target_cs", target_cs, r.b);
      end
      IFD_K_DIRECT: begin
        check("displacement", displacement, r.a);
        check("operand", operand, r.a);
        check("ea_needed", 16'(ea_needed), r.b);
      end
      IFD_K_ESC: check("escape", 16'(escape_opcode), r.a);
      IFD_K_MODRM: begin
        check("segment", 16'(segment_selector_field), 16'(r.a[1:0]));
        check("mode", 16'(mode_field), 16'(r.bytes[7:6]));
        check("reg_field", 16'(reg_field), 16'(r.bytes[5:3]));
        check("rm_field", 16'(rm_field), 16'(r.bytes[2:0]));
        check("op_select", 16'(op_select), 16'(r.a[4:2]));
        check("displacement", displacement, r.b);
        if (r.c[1]) check("ea_needed", 16'(ea_needed), 16'(r.c[0]));
      end
      default: ;
    endcase
  endtask : verify

  initial begin
    #60000;
    miscompares++;
    conclude();
  end

  initial begin
    rows = '{
      '{IFD_K_IMM, 8'h81, 1'h0, 16'h0, 3'h2, 48'h1234, 16'h1234, 16'h1, 2'h0},
      '{IFD_K_IMM, 8'h83, 1'h0, 16'h0, 3'h2, 48'h1234, 16'h1234, 16'h1, 2'h0},
      '{IFD_K_IMM, 8'h80, 1'h0, 16'h0, 3'h1, 48'hA5, 16'h00A5, 16'h0, 2'h0},
      '{IFD_K_MODRM_I, 8'h83, 1'h0, 16'h0, 3'h3, 48'hFE_8040, 16'h0080,
        16'hFFFE, 2'h0},
      '{IFD_K_MODRM_I, 8'h81, 1'h0, 16'h0, 3'h5, 48'h56_7812_3480, 16'h1234,
        16'h5678, 2'h0},
      '{IFD_K_MODRM_I, 8'h83, 1'h0, 16'h0, 3'h2, 48'h7F00, 16'h0, 16'h007F,
        2'h0},
      '{IFD_K_REL8, 8'h00, 1'h0, 16'h1000, 3'h1, 48'hFE, 16'h0FFE, 16'h0, 2'h0},
      '{IFD_K_REL8, 8'h00, 1'h0, 16'h1000, 3'h1, 48'h7F, 16'h107F, 16'h0, 2'h0},
      '{IFD_K_REL16, 8'h00, 1'h0, 16'h1000, 3'h2, 48'h8000, 16'h9000, 16'h0,
        2'h0},
      '{IFD_K_FAR, 8'h00, 1'h0, 16'h0, 3'h4, 48'h1234_5678, 16'h5678, 16'h1234,
        2'h0},
      '{IFD_K_DIRECT, 8'h00, 1'h0, 16'h0, 3'h2, 48'hABCD, 16'hABCD, 16'h0, 2'h0},
      '{IFD_K_ESC, 8'hDB, 1'h0, 16'h0, 3'h1, 48'h28, 16'h001D, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'h8C, 1'h0, 16'h0, 3'h1, 48'hC0, 16'h0, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'h8C, 1'h0, 16'h0, 3'h1, 48'hC8, 16'h1, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'h8C, 1'h0, 16'h0, 3'h1, 48'hD0, 16'h2, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'h8C, 1'h0, 16'h0, 3'h1, 48'hD8, 16'h3, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'hFF, 1'h1, 16'h0, 3'h1, 48'hF8, 16'h1F, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'hFF, 1'h0, 16'h0, 3'h1, 48'hF8, 16'h03, 16'h0, 2'h0},
      '{IFD_K_MODRM, 8'h8B, 1'h0, 16'h0, 3'h3, 48'h12_3406, 16'h0, 16'h1234,
        2'h2},
      '{IFD_K_MODRM, 8'h8B, 1'h0, 16'h0, 3'h2, 48'hFF40, 16'h0, 16'h00FF, 2'h3},
      '{IFD_K_NONE, 8'h90, 1'h0, 16'h0, 3'h0, 48'h0, 16'h0, 16'h0, 2'h0}
    };
    repeat (3) @(negedge ref_clk);
    check("busy", 16'(busy), 16'h0);
    check("mode", 16'(mode_field), 16'h3);
    check("segment", 16'(segment_selector_field), 16'h3);
    check("bus ctrl", 16'(internal_bus_ctrl), 16'h1);
    srst = 1'h0;
    foreach (rows[i]) begin
      run(rows[i]);
      verify(rows[i]);
    end
    // A start while a decode is under way must be ignored
    launch(rows[8]);
    byte_valid = 1'h1;
    byte_in = 8'h34;
    @(negedge ref_clk);
    start = 1'h1;
    kind = IFD_K_IMM;
    byte_in = 8'h12;
    @(negedge ref_clk);
    start = 1'h0;
    byte_valid = 1'h0;
    wait_done();
    check("target_ip", target_ip, 16'h2234);
    @(negedge ref_clk);
    check("busy", 16'(busy), 16'h0);
    strap = 1'h0;
    repeat (2) @(negedge ref_clk);
    check("bus ctrl", 16'(internal_bus_ctrl), 16'h0);
    strap = 1'h1;
    // Reset in mid-decode, then a clean decode afterwards
    launch(rows[9]);
    byte_valid = 1'h1;
    @(negedge ref_clk);
    byte_valid = 1'h0;
    srst = 1'h1;
    @(negedge ref_clk);
    srst = 1'h0;
    check("busy", 16'(busy), 16'h0);
    check("segment", 16'(segment_selector_field), 16'h3);
    run(rows[3]);
    verify(rows[3]);
    conclude();
  end
endmodule : test_ifd_decoder
`default_nettype wire
